// ==== mrzq_core.sv ====
// mode-register access, temperature status, training patterns and calibration control
// Operation
// - temperature status refreshed from sensor at least every 16 ms
// - temperature bits no older than update interval after low-power exit
// - temperature field reports 011 when case may exceed 85 C
// - pattern register A reads 1,0,1,0; pattern B reads 0,0,1,1
// - pattern bit driven on bit 0 and copied across every byte lane
// - register write decoded with select and CA0-CA3 low; address, data mapped
// - write to read-only register changes nothing
// - reset write restores defaults and enters auto-initialisation
// - four calibration kinds accepted, each with own completion interval
// - calibration pin circuitry switched off once calibration completes
// - register read decoded with CA0-CA2 low, CA3 high; four-beat burst
// - register data on low byte, first beat only
// - tied calibration pin: calibration commands ignored, defaults kept
`default_nettype none
module mrzq_core
    import mrzq_pkg::*;
#(
    parameter int unsigned DQ_W            = 16,
    parameter int unsigned SENSOR_CYCLES   = SENSOR_INTERVAL_CYC,
    parameter int unsigned RESET_CYCLES    = RESET_INIT_CYC,
    parameter int unsigned ZQ_INIT_CYCLES  = ZQ_INIT_CYC,
    parameter int unsigned ZQ_LONG_CYCLES  = ZQ_LONG_CYC,
    parameter int unsigned ZQ_SHORT_CYCLES = ZQ_SHORT_CYC,
    parameter int unsigned ZQ_RESET_CYCLES = ZQ_RESET_CYC,
    parameter int unsigned RL_CYCLES       = READ_LATENCY_CYC
)
(
    // clock, reset, enable
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            ce_i,
    // command/address bus
    input  wire ca_word_t        ca_i,
    // configuration and sensor
    input  wire cal_codes_t      codes_i,
    input  wire logic            cal_pin_tied_i,
    input  wire logic [2:0]      sensor_code_i,
    input  wire logic            low_power_exit_i,
    // read data
    output logic [DQ_W-1:0]      dq_o,
    output logic                 dq_oe_o,
    // status
    output logic [1:0]           cmd_state_o,
    output logic                 auto_init_o,
    output logic                 cal_busy_o,
    output logic                 cal_quiet_o,
    output logic                 cal_pin_active_o,
    output logic                 cal_done_o,
    output logic [7:0]           temp_status_o
);
    localparam int SW = 31;
    localparam int LANES = DQ_W / 8;

    // ****************************************************************
    // command decode
    // ****************************************************************
    logic       is_write, is_read;
    logic [7:0] cmd_addr, wr_data;

    assign is_write = !ca_i.cs_n && ca_i.ca_rise[3:0] == 4'h0;
    assign is_read  = !ca_i.cs_n && ca_i.ca_rise[3:0] == 4'h8;
    assign cmd_addr = {ca_i.ca_fall[1:0], ca_i.ca_rise[9:4]};
    assign wr_data  = ca_i.ca_fall[9:2];

    function automatic cal_kind_t decode_cal(input logic [7:0] d, input cal_codes_t c);
        if (d == c.init_code)       decode_cal = CAL_INIT;
        else if (d == c.long_code)  decode_cal = CAL_LONG;
        else if (d == c.short_code) decode_cal = CAL_SHORT;
        else if (d == c.reset_code) decode_cal = CAL_RESET;
        else                        decode_cal = CAL_NONE;
    endfunction : decode_cal

    // ****************************************************************
    // state
    // ****************************************************************
    cmd_state_t     st_r, st_nxt;
    logic [SW-1:0]  tmr_r, tmr_nxt;
    logic [SW-1:0]  sens_r, sens_nxt;
    logic [7:0]     temp_r, temp_nxt;
    logic [7:0]     gp_r [4];
    logic [7:0]     gp_nxt [4];
    logic [7:0]     rd_addr_r, rd_addr_nxt;
    logic [3:0]     beat_r, beat_nxt;
    logic [DQ_W-1:0] dq_r, dq_nxt;
    logic           oe_r, oe_nxt;
    logic           cal_start;
    cal_kind_t      cal_kind;

    always_comb
    begin
        st_nxt      = st_r;
        tmr_nxt     = tmr_r;
        sens_nxt    = sens_r;
        temp_nxt    = temp_r;
        gp_nxt      = gp_r;
        rd_addr_nxt = rd_addr_r;
        beat_nxt    = beat_r;
        dq_nxt      = dq_r;
        oe_nxt      = 1'b0;
        cal_start   = 1'b0;
        cal_kind    = CAL_NONE;

        // periodic sensor sampling; restart on exit from low power
        if (sens_r == '0 || low_power_exit_i)
        begin
            sens_nxt = SW'(SENSOR_CYCLES - 1);
            // sensor code already reports 011 when above 85 C
            temp_nxt = {5'h00, sensor_code_i};
        end
        else
        begin
            sens_nxt = sens_r - SW'(1);
        end

        case (st_r)
            ST_IDLE:
            begin
                if (is_write)
                begin
                    tmr_nxt = SW'(REG_WRITE_PERIOD_CYC - 1);
                    st_nxt  = ST_WRITE;
                    if (cmd_addr == ADDR_RESET)
                    begin
                        // every writable register back to default
                        for (int i = 0; i < 4; i++)
                            gp_nxt[i] = GP_RESET_VAL;
                        tmr_nxt = SW'(RESET_CYCLES - 1);
                        st_nxt  = ST_RESET;
                    end
                    else if (cmd_addr <= ADDR_GP_LAST)
                    begin
                        gp_nxt[cmd_addr[1:0]] = wr_data;
                    end
                    else if (cmd_addr == ADDR_IMP_CAL_CMD)
                    begin
                        cal_kind  = decode_cal(wr_data, codes_i);
                        cal_start = 1'b1;
                    end
                    // any other address is read-only: dropped silently
                end
                else if (is_read)
                begin
                    rd_addr_nxt = cmd_addr;
                    tmr_nxt     = SW'(RL_CYCLES + READ_BEATS - 1);
                    beat_nxt    = '0;
                    st_nxt      = ST_READ;
                end
            end
            ST_READ:
            begin
                // the low-byte value, pattern or spare beats
                if (tmr_r < SW'(READ_BEATS))
                begin
                    oe_nxt   = 1'b1;
                    beat_nxt = beat_r + 4'h1;
                    dq_nxt   = '0;
                    if (rd_addr_r == ADDR_CAL_PATT_A || rd_addr_r == ADDR_CAL_PATT_B)
                    begin
                        // bit 0 of each lane replicated across the lane
                        for (int l = 0; l < LANES; l++)
                            dq_nxt[l*8 +: 8] = {8{(rd_addr_r == ADDR_CAL_PATT_A)
                                ? PATT_A[beat_r[1:0]]
                                : PATT_B[beat_r[1:0]]}};
                    end
                    else if (beat_r == '0)
                    begin
                        // upper lanes and later beats carry don't-care zero
                        if (rd_addr_r == ADDR_TEMP_STATUS)
                            dq_nxt[7:0] = temp_r;
                        else if (rd_addr_r <= ADDR_GP_LAST)
                            dq_nxt[7:0] = gp_r[rd_addr_r[1:0]];
                    end
                end
                if (tmr_r == '0)
                    st_nxt = ST_IDLE;
                else
                    tmr_nxt = tmr_r - SW'(1);
            end
            ST_WRITE, ST_RESET:
            begin
                // only no-ops expected here; commands ignored
                if (tmr_r == '0)
                    st_nxt = ST_IDLE;
                else
                    tmr_nxt = tmr_r - SW'(1);
            end
            default:
            begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_r      <= ST_IDLE;
            tmr_r     <= '0;
            sens_r    <= '0;
            temp_r    <= {5'h00, TEMP_NORMAL_CODE};
            for (int i = 0; i < 4; i++)
                gp_r[i] <= GP_RESET_VAL;
            rd_addr_r <= '0;
            beat_r    <= '0;
            dq_r      <= '0;
            oe_r      <= 1'b0;
        end
        else if (ce_i)
        begin
            st_r      <= st_nxt;
            tmr_r     <= tmr_nxt;
            sens_r    <= sens_nxt;
            temp_r    <= temp_nxt;
            gp_r      <= gp_nxt;
            rd_addr_r <= rd_addr_nxt;
            beat_r    <= beat_nxt;
            dq_r      <= dq_nxt;
            oe_r      <= oe_nxt;
        end
    end

    // ****************************************************************
    // calibration
    // ****************************************************************
    mrzq_cal_engine #(
        .ZQ_INIT_CYCLES  (ZQ_INIT_CYCLES),
        .ZQ_LONG_CYCLES  (ZQ_LONG_CYCLES),
        .ZQ_SHORT_CYCLES (ZQ_SHORT_CYCLES),
        .ZQ_RESET_CYCLES (ZQ_RESET_CYCLES)
    ) u_cal (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .ce_i         (ce_i),
        .start_i      (cal_start),
        .kind_i       (cal_kind),
        .pin_tied_i   (cal_pin_tied_i),
        .busy_o       (cal_busy_o),
        .quiet_o      (cal_quiet_o),
        .pin_active_o (cal_pin_active_o),
        .done_o       (cal_done_o)
    );

    assign dq_o          = dq_r;
    assign dq_oe_o       = oe_r;
    assign cmd_state_o   = st_r;
    assign auto_init_o   = (st_r == ST_RESET);
    assign temp_status_o = temp_r;
endmodule : mrzq_core
`default_nettype wire

// ==== mrzq_pkg.sv ====
// package: constants and carrier types for the mode-register and impedance calibration block
`default_nettype none
package mrzq_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_PERIOD_NS        = 10;
    localparam int unsigned SENSOR_INTERVAL_MS   = 16;
    localparam int unsigned SENSOR_INTERVAL_CYC  = SENSOR_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned REG_READ_PERIOD_CYC  = 2;
    localparam int unsigned REG_WRITE_PERIOD_CYC = 5;
    localparam int unsigned RESET_INIT_CYC       = 20000;
    localparam int unsigned ZQ_INIT_CYC          = 100000;
    localparam int unsigned ZQ_LONG_CYC          = 36000;
    localparam int unsigned ZQ_SHORT_CYC         = 9000;
    localparam int unsigned ZQ_RESET_CYC         = 5000;
    localparam int unsigned READ_LATENCY_CYC     = 3;
    localparam int unsigned READ_BEATS           = 4;

    // ****************************************************************
    // register addresses and reset values
    // ****************************************************************
    localparam logic [7:0] ADDR_TEMP_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IMP_CAL_CMD  = 8'h0a;
    localparam logic [7:0] ADDR_CAL_PATT_A   = 8'h20;
    localparam logic [7:0] ADDR_CAL_PATT_B   = 8'h28;
    localparam logic [7:0] ADDR_RESET        = 8'h3f;
    localparam logic [7:0] ADDR_GP_LAST      = 8'h03;
    localparam logic [3:0] PATT_A            = 4'h5;
    localparam logic [3:0] PATT_B            = 4'hc;
    localparam logic [2:0] TEMP_HOT_CODE     = 3'h3;
    localparam logic [2:0] TEMP_NORMAL_CODE  = 3'h2;
    localparam logic [7:0] GP_RESET_VAL      = 8'h00;

    // default command codes written to the calibration command register
    localparam logic [7:0] CODE_ZQ_INIT  = 8'hff;
    localparam logic [7:0] CODE_ZQ_LONG  = 8'hab;
    localparam logic [7:0] CODE_ZQ_SHORT = 8'h56;
    localparam logic [7:0] CODE_ZQ_RESET = 8'hc3;

    typedef enum logic [2:0] {
        CAL_NONE  = 3'b000,
        CAL_INIT  = 3'b001,
        CAL_LONG  = 3'b010,
        CAL_SHORT = 3'b011,
        CAL_RESET = 3'b100
    } cal_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_READ    = 2'b01,
        ST_WRITE   = 2'b10,
        ST_RESET   = 2'b11
    } cmd_state_t;

    // command/address captured at rise and fall of one clock
    typedef struct packed {
        logic       cs_n;
        logic [9:0] ca_rise;
        logic [9:0] ca_fall;
    } ca_word_t;

    typedef struct packed {
        logic [7:0] init_code;
        logic [7:0] long_code;
        logic [7:0] short_code;
        logic [7:0] reset_code;
    } cal_codes_t;
endpackage : mrzq_pkg
`default_nettype wire

// ==== mrzq_cal_engine.sv ====
// impedance calibration sequencer with a per-kind completion interval
`default_nettype none
module mrzq_cal_engine
    import mrzq_pkg::*;
#(
    parameter int unsigned ZQ_INIT_CYCLES  = ZQ_INIT_CYC,
    parameter int unsigned ZQ_LONG_CYCLES  = ZQ_LONG_CYC,
    parameter int unsigned ZQ_SHORT_CYCLES = ZQ_SHORT_CYC,
    parameter int unsigned ZQ_RESET_CYCLES = ZQ_RESET_CYC
)
(
    // clock and reset
    input  wire logic      clk_i,
    input  wire logic      rst_i,
    input  wire logic      ce_i,
    // request
    input  wire logic      start_i,
    input  wire cal_kind_t kind_i,
    input  wire logic      pin_tied_i,
    // status
    output logic           busy_o,
    output logic           quiet_o,
    output logic           pin_active_o,
    output logic           done_o
);
    localparam int CW = 17;

    cal_kind_t     kind_r, kind_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          busy_r, busy_nxt;
    logic          done_r, done_nxt;

    function automatic logic [CW-1:0] span(input cal_kind_t k);
        case (k)
            CAL_INIT:  span = CW'(ZQ_INIT_CYCLES - 1);
            CAL_LONG:  span = CW'(ZQ_LONG_CYCLES - 1);
            CAL_SHORT: span = CW'(ZQ_SHORT_CYCLES - 1);
            CAL_RESET: span = CW'(ZQ_RESET_CYCLES - 1);
            default:   span = '0;
        endcase
    endfunction : span

    always_comb
    begin
        kind_nxt = kind_r;
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        // no resistor fitted: commands are dropped, defaults kept
        if (!busy_r && start_i && !pin_tied_i && kind_i != CAL_NONE)
        begin
            kind_nxt = kind_i;
            cnt_nxt  = span(kind_i);
            busy_nxt = 1'b1;
        end
        else if (busy_r)
        begin
            if (cnt_r == '0)
            begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                kind_nxt = CAL_NONE;
            end
            else
            begin
                cnt_nxt = cnt_r - CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            kind_r <= CAL_NONE;
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (ce_i)
        begin
            kind_r <= kind_nxt;
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy_o       = busy_r;
    // reset-to-default needs no quiet bus
    assign quiet_o      = busy_r && kind_r != CAL_RESET;
    // pin circuitry only powered while calibrating
    assign pin_active_o = busy_r;
    assign done_o       = done_r;
endmodule : mrzq_cal_engine
`default_nettype wire

// ==== mrzq_core_properties.sv ====
// port-level properties of the mode-register and calibration core
`default_nettype none
module mrzq_core_properties
    import mrzq_pkg::*;
#(
    parameter int unsigned DQ_W            = 16,
    parameter int unsigned SENSOR_CYCLES   = 100,
    parameter int unsigned RESET_CYCLES    = 20,
    parameter int unsigned ZQ_SHORT_CYCLES = 20,
    parameter int unsigned RL_CYCLES       = 3
)
(
    // clock, reset, inputs
    input wire logic            clk_i,
    input wire logic            rst_i,
    input wire logic            ce_i,
    input wire ca_word_t        ca_i,
    input wire cal_codes_t      codes_i,
    input wire logic            cal_pin_tied_i,
    input wire logic [2:0]      sensor_code_i,
    input wire logic            low_power_exit_i,
    // outputs
    input wire logic [DQ_W-1:0] dq_o,
    input wire logic            dq_oe_o,
    input wire logic [1:0]      cmd_state_o,
    input wire logic            auto_init_o,
    input wire logic            cal_busy_o,
    input wire logic            cal_quiet_o,
    input wire logic            cal_pin_active_o,
    input wire logic            cal_done_o,
    input wire logic [7:0]      temp_status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // beats launch RL+1 edges after the take and are sampled one edge later
    localparam int RLD = RL_CYCLES + 2;
    localparam int RC1 = RESET_CYCLES - 1;
    localparam int SHL = ZQ_SHORT_CYCLES - 3;
    localparam int SHH = ZQ_SHORT_CYCLES;
    localparam logic [DQ_W-1:0] ONES = '1;
    logic        sel_idle;
    logic        wr_take;
    logic        rd_take;
    logic        cal_go;
    logic [7:0]  addr;
    logic [7:0]  wdat;
    int unsigned stale_r;
    int unsigned stale_nxt;
    assign sel_idle = ce_i && cmd_state_o == 2'h0 && !ca_i.cs_n;
    assign wr_take  = sel_idle && ca_i.ca_rise[3:0] == 4'h0;
    assign rd_take  = sel_idle && ca_i.ca_rise[3:0] == 4'h8;
    assign addr     = {ca_i.ca_fall[1:0], ca_i.ca_rise[9:4]};
    assign wdat     = ca_i.ca_fall[9:2];
    assign cal_go   = wr_take && addr == ADDR_IMP_CAL_CMD && !cal_busy_o && !cal_pin_tied_i;
    // age of a status that disagrees with the sensor; frozen while disabled
    always_comb
    begin
        stale_nxt = stale_r;
        if (ce_i)
        begin
            stale_nxt = (temp_status_o[2:0] != sensor_code_i) ? stale_r + 1 : 0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i) stale_r <= 0;
        else stale_r <= stale_nxt;
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence write_hold;
        (cmd_state_o == 2'h2) [*5] ##1 (cmd_state_o == 2'h0);
    endsequence
    sequence reset_span;
        (auto_init_o && cmd_state_o == 2'h3) throughout (1'b1 ##[RC1:RC1] 1'b1);
    endsequence
    sequence beats_a;
        dq_o == ONES ##1 dq_o == '0 ##1 dq_o == ONES ##1 dq_o == '0;
    endsequence
    sequence beats_b;
        dq_o == '0 ##1 dq_o == '0 ##1 dq_o == ONES ##1 dq_o == ONES;
    endsequence
    a_write_decode: assert property (wr_take && addr < 8'h04 |=> write_hold)
        else $error("register write period wrong");
    a_reset_write: assert property (wr_take && addr == ADDR_RESET
        |=> reset_span ##1 cmd_state_o == 2'h0) else $error("reset write span wrong");
    a_read_burst: assert property (rd_take |-> ##[RLD:RLD] dq_oe_o [*4] ##1 !dq_oe_o)
        else $error("read burst length wrong");
    a_pattern_a: assert property (rd_take && addr == ADDR_CAL_PATT_A
        |-> ##[RLD:RLD] beats_a) else $error("pattern A wrong");
    a_pattern_b: assert property (rd_take && addr == ADDR_CAL_PATT_B
        |-> ##[RLD:RLD] beats_b) else $error("pattern B wrong");
    a_exit_fresh: assert property (ce_i && low_power_exit_i
        |=> temp_status_o[2:0] == $past(sensor_code_i)) else $error("stale status at exit");
    a_sensor_age: assert property (stale_r <= SENSOR_CYCLES + 1)
        else $error("temperature status too old");
    a_cal_short: assert property (cal_go && wdat == codes_i.short_code
        |=> (cal_busy_o && cal_quiet_o) [*2] ##[SHL:SHH] cal_done_o)
        else $error("short calibration timing wrong");
    a_cal_reset: assert property (cal_go && wdat == codes_i.reset_code
        |=> cal_busy_o && !cal_quiet_o) else $error("reset calibration quiet wrong");
    a_cal_tied: assert property (wr_take && addr == ADDR_IMP_CAL_CMD && cal_pin_tied_i
        && !cal_busy_o |=> !cal_busy_o [*2]) else $error("tied pin calibration started");
    a_pin_off: assert property ($fell(cal_busy_o) |-> ##[0:1] !cal_pin_active_o)
        else $error("calibration pin left active");
endmodule : mrzq_core_properties
bind mrzq_core mrzq_core_properties #(.DQ_W(DQ_W), .SENSOR_CYCLES(SENSOR_CYCLES),
    .RESET_CYCLES(RESET_CYCLES), .ZQ_SHORT_CYCLES(ZQ_SHORT_CYCLES), .RL_CYCLES(RL_CYCLES))
    u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ca_i(ca_i), .codes_i(codes_i),
    .cal_pin_tied_i(cal_pin_tied_i), .sensor_code_i(sensor_code_i),
    .low_power_exit_i(low_power_exit_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .cmd_state_o(cmd_state_o), .auto_init_o(auto_init_o), .cal_busy_o(cal_busy_o),
    .cal_quiet_o(cal_quiet_o), .cal_pin_active_o(cal_pin_active_o),
    .cal_done_o(cal_done_o), .temp_status_o(temp_status_o));
`default_nettype wire

// ==== mrzq_ctrl_model.sv ====
// memory controller model driving the command/address bus
`default_nettype none
module mrzq_ctrl_model
    import mrzq_pkg::*;
#(
    parameter int unsigned GAP = 8
)
(
    // device status seen by the controller
    input  wire logic       clk_i,
    input  wire logic [1:0] state_i,
    input  wire logic       cal_busy_i,
    // command/address bus
    output var ca_word_t    ca_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial ca_o = {1'b1, 10'h155, 10'h2aa};
    // gap covers read-to-write, burst-to-read and turnaround spacing
    task automatic send(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int guard;
        repeat (GAP) @(posedge clk_i);
        guard = 0;
        // idle and no calibration running before any command
        while (!(state_i == 2'h0 && !cal_busy_i) && guard < 5000)
        begin
            @(posedge clk_i);
            guard++;
        end
        @(posedge clk_i);
        ca_o <= {1'b0, addr[5:0], (wr ? 4'h0 : 4'h8), data, addr[7:6]};
        @(posedge clk_i);
        // deselected: lines toggle so nothing stale is read
        ca_o <= {1'b1, ~ca_o.ca_rise, ~ca_o.ca_fall};
    endtask : send
endmodule : mrzq_ctrl_model
`default_nettype wire

// ==== mrzq_core_bench.sv ====
// self-checking testbench of the mode-register and calibration core
`default_nettype none
module mrzq_core_bench;
    import mrzq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SENS = 100;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i  = 1'b1;
    ca_word_t    ca;
    logic [7:0]  kc [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    int          cl [4] = '{40, 30, 20, 10};
    cal_codes_t  codes;
    logic        tied  = 1'b0;
    logic [2:0]  sensor = 3'h2;
    logic        lpe   = 1'b0;
    logic [15:0] dq;
    logic        dq_oe, auto_init, busy, quiet, pin, done;
    logic [1:0]  state;
    logic [7:0]  temp;
    logic [15:0] bt [4];
    int          nb, num_errors, n_tests;
    assign codes = {kc[0], kc[1], kc[2], kc[3]};
    always #5 clk_i = ~clk_i;
    mrzq_core #(.SENSOR_CYCLES(SENS), .RESET_CYCLES(20), .ZQ_INIT_CYCLES(40),
        .ZQ_LONG_CYCLES(30), .ZQ_SHORT_CYCLES(20), .ZQ_RESET_CYCLES(10))
    u_mrzq_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .ca_i(ca), .codes_i(codes),
        .cal_pin_tied_i(tied), .sensor_code_i(sensor), .low_power_exit_i(lpe), .dq_o(dq),
        .dq_oe_o(dq_oe), .cmd_state_o(state), .auto_init_o(auto_init), .cal_busy_o(busy),
        .cal_quiet_o(quiet), .cal_pin_active_o(pin), .cal_done_o(done), .temp_status_o(temp));
    mrzq_ctrl_model u_mrzq_ctrl_model (.clk_i(clk_i), .state_i(state), .cal_busy_i(busy),
        .ca_o(ca));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] addr);
        u_mrzq_ctrl_model.send(1'b0, addr, 8'h00);
        nb = 0;
        repeat (12)
        begin
            #1;
            if (dq_oe === 1'b1 && nb < 4)
            begin
                bt[nb] = dq;
                nb++;
            end
            @(posedge clk_i);
        end
        chk("beat count", 16'h0004, 16'(nb));
    endtask : rd
    task automatic t_temp();
        @(posedge clk_i);
        sensor <= 3'h3;
        lpe <= 1'b1;
        @(posedge clk_i);
        lpe <= 1'b0;
        #1 chk("status at exit", 16'h0003, {13'h0, temp[2:0]});
        rd(ADDR_TEMP_STATUS);
        chk("hot status", 16'h0003, {8'h00, bt[0][7:0]});
        $display("test temp done");
    endtask : t_temp
    task automatic t_patt();
        logic [3:0] pa;
        logic [3:0] pb;
        pa = 4'b0101;
        pb = 4'b1100;
        u_mrzq_ctrl_model.send(1'b1, ADDR_CAL_PATT_B, 8'h00);
        rd(ADDR_CAL_PATT_A);
        for (int i = 0; i < 4; i++) chk("pattern a", {16{pa[i]}}, bt[i]);
        rd(ADDR_CAL_PATT_B);
        for (int i = 0; i < 4; i++) chk("pattern b", {16{pb[i]}}, bt[i]);
        $display("test patt done");
    endtask : t_patt
    task automatic t_regs();
        u_mrzq_ctrl_model.send(1'b1, 8'h03, 8'ha5);
        rd(8'h03);
        chk("general reg", 16'h00a5, {8'h00, bt[0][7:0]});
        u_mrzq_ctrl_model.send(1'b1, ADDR_RESET, 8'h00);
        #1 chk("auto init", 16'h0001, {15'h0, auto_init});
        rd(8'h03);
        chk("reg after reset", 16'h0000, {8'h00, bt[0][7:0]});
        $display("test regs done");
    endtask : t_regs
    task automatic t_cal();
        int nbusy;
        int ndone;
        logic q;
        for (int k = 0; k < 4; k++)
        begin
            u_mrzq_ctrl_model.send(1'b1, ADDR_IMP_CAL_CMD, kc[k]);
            nbusy = 0;
            ndone = 0;
            q = 1'b0;
            repeat (60)
            begin
                #1;
                nbusy += int'(busy === 1'b1);
                ndone += int'(done === 1'b1);
                q |= (quiet === 1'b1);
                @(posedge clk_i);
            end
            chk("cal length", 16'(cl[k]), 16'(nbusy));
            chk("cal done", 16'h0001, 16'(ndone));
            chk("cal quiet", {15'h0, k != 3}, {15'h0, q});
            chk("cal pin off", 16'h0000, {15'h0, pin});
        end
        tied <= 1'b1;
        u_mrzq_ctrl_model.send(1'b1, ADDR_IMP_CAL_CMD, kc[2]);
        nbusy = 0;
        repeat (30)
        begin
            #1 nbusy += int'(busy !== 1'b0);
            @(posedge clk_i);
        end
        chk("tied cal", 16'h0000, 16'(nbusy));
        tied <= 1'b0;
        $display("test cal done");
    endtask : t_cal
    task automatic t_sensor();
        sensor <= 3'h1;
        repeat (SENS + 2) @(posedge clk_i);
        #1 chk("sensor update", 16'h0001, {13'h0, temp[2:0]});
        $display("test sensor done");
    endtask : t_sensor
    task automatic t_hold();
        @(posedge clk_i);
        ce_i   <= 1'b0;
        sensor <= 3'h4;
        repeat (SENS + 2) @(posedge clk_i);
        ce_i <= 1'b1;
        // enable low: sensor timer and status must not move
        #1 chk("frozen status", 16'h0001, {13'h0, temp[2:0]});
        repeat (SENS + 2) @(posedge clk_i);
        #1 chk("resumed status", 16'h0004, {13'h0, temp[2:0]});
        $display("test hold done");
    endtask : t_hold
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        #100000;
        num_errors++;
        $display("[FAIL] watchdog expected finish seen hang");
        give_verdict();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 chk("idle after reset", 16'h0000, {13'h0, dq_oe, state});
        t_temp();
        t_patt();
        t_regs();
        t_cal();
        t_sensor();
        t_hold();
        give_verdict();
    end
endmodule : mrzq_core_bench
`default_nettype wire
